// file: src/lcd_column_driver.sv
/*
  Column data shift and latch logic of a 160 column segment driver:
  word capture on the pixel shift clock, daisy chained enable, line latch
  and column drive level selection on the system clock.
  Assumes a 125 MHz system clock, a shift clock of at most 12 MHz that may
  stop between lines, and pins that are asynchronous to the system clock.
*/
// Overview of operation
// - 160 column outputs change data only at falling line latch, else hold
// - pixel data bus is 8 bits (DATA_W), one word per shift clock
// - capture one bus word at each falling shift clock while chain enabled
// - falling line latch moves all collected bits to output latch at once
// - direction low: pin1 output, pin2 input; high: the reverse
// - chain output goes high at line latch, low after 160 bits fetched
// - direction low: first bit to column 159 descending; high: reversed
// - bit-to-column mapping independent of number of shift clocks issued
// - frame polarity alternates the drive level for AC drive
// - forced blank low drives every column to bottom level
// - daisy chained enable replaces per-driver select lines
// - blank high: data and polarity select top, bottom or middle levels
// - chain input inactive: standby, no capture, internal bus held low
`timescale 1ns/100ps
module lcd_column_driver
(
  input  wire logic                                 clock,
  input  wire logic                                 reset,
  input  wire logic                                 pixel_shift_clock,
  input  wire logic [lcd_pkg::DATA_W-1:0]           pixel_data_bus,
  input  wire logic                                 line_latch_pulse,
  input  wire logic                                 scan_direction_select,
  input  wire logic                                 frame_polarity,
  input  wire logic                                 forced_blank_n,
  input  wire logic                                 chain_enable_pin1_in,
  output      logic                                 chain_enable_pin1_out,
  output      logic                                 chain_enable_pin1_oe_n,
  input  wire logic                                 chain_enable_pin2_in,
  output      logic                                 chain_enable_pin2_out,
  output      logic                                 chain_enable_pin2_oe_n,
  output      lcd_pkg::lcd_level_e [lcd_pkg::COLS-1:0] column_outputs,
  output      logic                                 fetch_done,
  output      logic [lcd_pkg::CNT_W-1:0]            words_taken
);
  import lcd_pkg::*;

  // ==========================================================
  // declarations
  lcd_col_if ifc ();

  logic                lrst_meta_ff;
  logic                lrst_ff;
  logic                ldir_meta_ff;
  logic                ldir_ff;
  logic                link_enabled;
  lcd_word_t           masked_word;
  logic                ltgl_ff;
  lcd_word_t [1:0]     lslot_ff;

  logic [SYNC_N-1:0]   async_in;
  logic [SYNC_N-1:0]   s1_ff;
  logic [SYNC_N-1:0]   s2_ff;
  logic [SYNC_N-1:0]   s3_ff;
  logic [SYNC_N-1:0]   stable_ff;
  logic [SYNC_N-1:0]   upd;

  logic                word_evt;
  logic                latch_fall;
  logic                latch_rise;

  logic [CNT_W-1:0]    count_ff;
  logic [CNT_W-1:0]    nxt_count;
  logic                full_ff;
  logic                chain_out_ff;
  logic                wr_en_ff;
  logic [IDX_W-1:0]    wr_idx_ff;
  lcd_word_t           wr_data_ff;
  logic                xfer_ff;
  logic                pin1_oe_n_ff;
  logic                pin2_oe_n_ff;
  lcd_level_e [COLS-1:0] column_ff;

  // ==========================================================
  // link domain: reset and direction crossings
  always_ff @(negedge pixel_shift_clock)
  begin
    lrst_meta_ff <= reset;
    lrst_ff      <= lrst_meta_ff;
    ldir_meta_ff <= scan_direction_select;
    ldir_ff      <= ldir_meta_ff;
  end

  // ==========================================================
  // link domain: word capture
  assign link_enabled = ~(ldir_ff ? chain_enable_pin1_in : chain_enable_pin2_in);
  assign masked_word  = link_enabled ? pixel_data_bus : '0;

  always_ff @(negedge pixel_shift_clock)
  begin
    if (lrst_ff)
    begin
      ltgl_ff  <= 1'b0;
      lslot_ff <= '0;
    end
    else if (link_enabled)
    begin
      lslot_ff[~ltgl_ff] <= masked_word;
      ltgl_ff            <= ~ltgl_ff;
    end
  end

  // ==========================================================
  // system domain: three stage synchronisers
  assign async_in[AS_TGL]   = ltgl_ff;
  assign async_in[AS_LATCH] = line_latch_pulse;
  assign async_in[AS_FR]    = frame_polarity;
  assign async_in[AS_BLANK] = forced_blank_n;
  assign async_in[AS_DIR]   = scan_direction_select;

  genvar i;
  generate
    for (i = 0; i < SYNC_N; i++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          s1_ff[i]     <= SYNC_RST[i];
          s2_ff[i]     <= SYNC_RST[i];
          s3_ff[i]     <= SYNC_RST[i];
          stable_ff[i] <= SYNC_RST[i];
        end
        else
        begin
          s1_ff[i] <= async_in[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          if (upd[i])
            stable_ff[i] <= s3_ff[i];
        end
      end
      assign upd[i] = (s2_ff[i] == s3_ff[i]) && (s3_ff[i] != stable_ff[i]);
    end
  endgenerate

  assign word_evt   = upd[AS_TGL];
  assign latch_fall = upd[AS_LATCH] && !s3_ff[AS_LATCH];
  assign latch_rise = upd[AS_LATCH] && s3_ff[AS_LATCH];

  // ==========================================================
  // fetch counter
  always_comb
  begin
    nxt_count = count_ff;
    if (latch_fall)
      nxt_count = CNT_RST;
    else if (word_evt && !full_ff)
      nxt_count = count_ff + 5'h01;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      count_ff <= CNT_RST;
      full_ff  <= 1'b0;
    end
    else
    begin
      count_ff <= nxt_count;
      if (latch_fall)
        full_ff <= 1'b0;
      else if (word_evt && !full_ff && count_ff[IDX_W-1:0] == LAST_IDX)
        full_ff <= 1'b1;
    end
  end

  // ==========================================================
  // word write into the shift stage
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_en_ff   <= 1'b0;
      wr_idx_ff  <= '0;
      wr_data_ff <= '0;
    end
    else
    begin
      wr_en_ff <= word_evt && !full_ff && !latch_fall;
      if (word_evt)
      begin
        wr_idx_ff  <= count_ff[IDX_W-1:0];
        wr_data_ff <= lslot_ff[s3_ff[AS_TGL]];
      end
    end
  end

  // ==========================================================
  // line transfer
  always_ff @(posedge clock)
  begin
    if (reset)
      xfer_ff <= 1'b0;
    else
      xfer_ff <= latch_fall;
  end

  // ==========================================================
  // chain enable output and pin direction
  always_ff @(posedge clock)
  begin
    if (reset)
      chain_out_ff <= CHAIN_IDLE;
    else if (latch_rise || latch_fall)
      chain_out_ff <= CHAIN_IDLE;
    else if (word_evt && !full_ff && count_ff[IDX_W-1:0] == LAST_IDX)
      chain_out_ff <= CHAIN_DONE;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pin1_oe_n_ff <= 1'b0;
      pin2_oe_n_ff <= 1'b1;
    end
    else
    begin
      pin1_oe_n_ff <= stable_ff[AS_DIR];
      pin2_oe_n_ff <= ~stable_ff[AS_DIR];
    end
  end

  // ==========================================================
  // store, encoder and column output register
  assign ifc.wr_en   = wr_en_ff;
  assign ifc.wr_idx  = wr_idx_ff;
  assign ifc.wr_data = wr_data_ff;
  assign ifc.xfer    = xfer_ff;
  assign ifc.dir     = stable_ff[AS_DIR];
  assign ifc.blank_n = stable_ff[AS_BLANK];
  assign ifc.fr      = stable_ff[AS_FR];

  lcd_line_store u_store
  (
    .clock (clock),
    .reset (reset),
    .ifc   (ifc.store)
  );

  lcd_level_enc u_enc
  (
    .ifc (ifc.enc)
  );

  always_ff @(posedge clock)
  begin
    if (reset)
      column_ff <= '{default: LVL_BOTTOM};
    else
      column_ff <= ifc.level;
  end

  // ==========================================================
  // outputs
  assign column_outputs         = column_ff;
  assign chain_enable_pin1_out  = chain_out_ff;
  assign chain_enable_pin2_out  = chain_out_ff;
  assign chain_enable_pin1_oe_n = pin1_oe_n_ff;
  assign chain_enable_pin2_oe_n = pin2_oe_n_ff;
  assign fetch_done             = full_ff;
  assign words_taken            = count_ff;

endmodule // lcd_column_driver

// file: shared/lcd_pkg.sv
/*
  Package for the column data shift and latch block: widths, counts,
  synchroniser layout, reset values, drive levels and the level decode.
  Assumes one 125 MHz system clock and a separate pixel shift clock.
*/
package lcd_pkg;

  // ==========================================================
  // geometry
  localparam int COLS     = 160;
  localparam int DATA_W   = 8;
  localparam int WORDS    = COLS / DATA_W;
  localparam int IDX_W    = 5;
  localparam int CNT_W    = 5;

  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(WORDS - 1);
  localparam logic [CNT_W-1:0] CNT_RST  = 5'h00;

  // ==========================================================
  // chain enable levels
  localparam logic CHAIN_IDLE = 1'b1;
  localparam logic CHAIN_DONE = 1'b0;

  // ==========================================================
  // synchroniser vector layout and reset values
  localparam int SYNC_N   = 5;
  localparam int AS_TGL   = 0;
  localparam int AS_LATCH = 1;
  localparam int AS_FR    = 2;
  localparam int AS_BLANK = 3;
  localparam int AS_DIR   = 4;

  localparam logic [SYNC_N-1:0] SYNC_RST = 5'h00;

  // ==========================================================
  // drive levels
  typedef enum logic [1:0]
  {
    LVL_BOTTOM    = 2'b00,
    LVL_LOWER_MID = 2'b01,
    LVL_UPPER_MID = 2'b10,
    LVL_TOP       = 2'b11
  } lcd_level_e;

  typedef logic [DATA_W-1:0] lcd_word_t;

  // ==========================================================
  // level decode for one column
  function automatic lcd_level_e lcd_level_of(input logic blank_n,
                                              input logic data,
                                              input logic fr);
    lcd_level_e lvl;
    lvl = LVL_BOTTOM;
    if (blank_n)
    begin
      case ({data, fr})
        2'b11:   lvl = LVL_TOP;
        2'b10:   lvl = LVL_BOTTOM;
        2'b01:   lvl = LVL_UPPER_MID;
        2'b00:   lvl = LVL_LOWER_MID;
        default: lvl = LVL_BOTTOM;
      endcase
    end
    return lvl;
  endfunction

endpackage

// file: shared/lcd_col_if.sv
/*
  Interface carrying word writes, the line transfer and the latched
  line between the control module, the line store and the encoder.
  Assumes all three sit on the system clock.
*/
`timescale 1ns/100ps
interface lcd_col_if;
  import lcd_pkg::*;

  logic                     wr_en;
  logic [IDX_W-1:0]         wr_idx;
  lcd_word_t                wr_data;
  logic                     xfer;
  logic                     dir;
  logic [COLS-1:0]          line;
  logic                     blank_n;
  logic                     fr;
  lcd_level_e [COLS-1:0]    level;

  modport ctrl  (output wr_en, wr_idx, wr_data, xfer, dir, blank_n, fr, input level);
  modport store (input wr_en, wr_idx, wr_data, xfer, dir, output line);
  modport enc   (input line, blank_n, fr, output level);
endinterface

// file: src/lcd_line_store.sv
/*
  Shift stage of one line and its output latch, read out from a register.
  Assumes writes and the transfer never fall in the same cycle.
*/
`timescale 1ns/100ps
module lcd_line_store
(
  input  wire logic  clock,
  input  wire logic  reset,
  lcd_col_if.store   ifc
);
  import lcd_pkg::*;

  lcd_word_t [WORDS-1:0] stage_ff;
  logic      [COLS-1:0]  stream;
  logic      [COLS-1:0]  line_ff;

  // ==========================================================
  // shift stage
  always_ff @(posedge clock)
  begin
    if (reset || ifc.xfer)
      stage_ff <= '0;
    else if (ifc.wr_en)
      stage_ff[ifc.wr_idx] <= ifc.wr_data;
  end

  assign stream = stage_ff;

  // ==========================================================
  // output latch, column order set by direction
  genvar c;
  generate
    for (c = 0; c < COLS; c++)
    begin : g_col
      always_ff @(posedge clock)
      begin
        if (reset)
          line_ff[c] <= 1'b0;
        else if (ifc.xfer)
          line_ff[c] <= ifc.dir ? stream[c] : stream[COLS-1-c];
      end
    end
  endgenerate

  assign ifc.line = line_ff;

endmodule // lcd_line_store

// file: src/lcd_level_enc.sv
/*
  Decodes each latched column bit into its drive level.
  Assumes the caller registers the result.
*/
`timescale 1ns/100ps
module lcd_level_enc
(
  lcd_col_if.enc ifc
);
  import lcd_pkg::*;

  genvar c;
  generate
    for (c = 0; c < COLS; c++)
    begin : g_lvl
      assign ifc.level[c] = lcd_level_of(ifc.blank_n, ifc.line[c], ifc.fr);
    end
  endgenerate

endmodule // lcd_level_enc

// file: dv/lcd_cd_asserts.sv
/*
  Port checker of the column driver.
  Assumes it is bound into lcd_column_driver.
*/
`timescale 1ns/100ps
module lcd_cd_asserts
(
  input wire logic clock,
  input wire logic reset,
  input wire logic line_latch_pulse,
  input wire logic scan_direction_select,
  input wire logic frame_polarity,
  input wire logic forced_blank_n,
  input wire logic chain_enable_pin1_out,
  input wire logic chain_enable_pin1_oe_n,
  input wire logic chain_enable_pin2_out,
  input wire logic chain_enable_pin2_oe_n,
  input wire lcd_pkg::lcd_level_e [lcd_pkg::COLS-1:0] column_outputs,
  input wire logic fetch_done,
  input wire logic [lcd_pkg::CNT_W-1:0] words_taken
);
  import lcd_pkg::*;
  // ========
  // age since reset
  logic [3:0] age_ff;
  always_ff @(posedge clock)
    if (reset)
      age_ff <= 4'h0;
    else if (age_ff != 4'hF)
      age_ff <= age_ff + 4'h1;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ========
  // checks
  chk_oe_dir: assert property
    ($stable(scan_direction_select) [*8] |-> chain_enable_pin1_oe_n == scan_direction_select
     && chain_enable_pin2_oe_n != scan_direction_select) else $error("pin enable vs direction");
  chk_done_count: assert property
    (fetch_done == (words_taken == CNT_W'(WORDS))) else $error("done vs count");
  chk_count_step: assert property
    (words_taken != $past(words_taken) |-> words_taken == $past(words_taken) + 5'h01
     || words_taken == 5'h00) else $error("count jumped");
  chk_chain_low: assert property
    ($rose(fetch_done) |-> !chain_enable_pin1_out && !chain_enable_pin2_out)
    else $error("chain out not low");
  chk_chain_idle: assert property
    ($fell(fetch_done) |-> chain_enable_pin1_out && chain_enable_pin2_out)
    else $error("chain out not idle");
  chk_count_clear: assert property
    ($fell(line_latch_pulse) |-> ##[1:8] words_taken == 5'h00) else $error("count not cleared");
  chk_cols_hold: assert property
    ((age_ff == 4'hF && $stable(line_latch_pulse) && $stable(frame_polarity)
      && $stable(forced_blank_n)) [*8] |=> $stable(column_outputs)) else $error("columns moved");
  chk_blank_bottom: assert property
    (!forced_blank_n [*8] |-> column_outputs == '0) else $error("blank not bottom");
endmodule // lcd_cd_asserts

bind lcd_column_driver lcd_cd_asserts u_chk
(
  .clock, .reset, .line_latch_pulse, .scan_direction_select, .frame_polarity,
  .forced_blank_n, .chain_enable_pin1_out, .chain_enable_pin1_oe_n,
  .chain_enable_pin2_out, .chain_enable_pin2_oe_n, .column_outputs,
  .fetch_done, .words_taken
);

// file: dv/lcd_ctl_model.sv
/*
  Panel controller model: shift clock, data words and line latch.
  Assumes a free 12 ns base clock lk from the bench.
*/
`timescale 1ns/100ps
module lcd_ctl_model
(
  input  wire logic       lk,
  output logic            sclk,
  output lcd_pkg::lcd_word_t data,
  output logic            ll
);
  import lcd_pkg::*;
  // no test input on this block, so it stays low
  initial
  begin
    sclk = 1'b0;
    data = '0;
    ll = 1'b0;
  end
  // one word per shift clock, 108 ns period, stops low between words
  task automatic word(input lcd_word_t w);
    @(posedge lk);
    data <= w;
    sclk <= 1'b1;
    repeat (4) @(posedge lk);
    sclk <= 1'b0;
    repeat (3) @(posedge lk);
    data <= ~w;
    @(posedge lk);
  endtask
  // latch pulse kept well clear of shift edges
  task automatic latch;
    repeat (6) @(posedge lk);
    ll <= 1'b1;
    repeat (6) @(posedge lk);
    ll <= 1'b0;
    repeat (6) @(posedge lk);
  endtask
endmodule // lcd_ctl_model

// file: dv/tb_top.sv
/*
  Self-checking bench of the column driver.
  Assumes the package, the controller model and the checker.
*/
`timescale 1ns/100ps
module tb_top;
  import lcd_pkg::*;
  // ========
  // signals
  logic clock = 0, reset = 1, lk = 0;
  logic dir = 0, fr = 1, bl = 1, hi = 1;
  logic sc, ll, o1, e1, o2, e2, dn;
  lcd_word_t db;
  lcd_level_e [COLS-1:0] col;
  logic [CNT_W-1:0] wt;
  logic [COLS-1:0] lastb;
  logic [2*COLS-1:0] q[$];
  logic [31:0] seed = 32'h6619;
  int failures = 0, comparisons = 0;
  event poke;
  wire p1 = e1 ? hi : o1;
  wire p2 = e2 ? hi : o2;

  always #4 clock = ~clock;
  initial #1.3 forever #6 lk = ~lk;

  lcd_ctl_model ctl (.lk(lk), .sclk(sc), .data(db), .ll(ll));
  lcd_column_driver uut
  (
    .clock, .reset,
    .pixel_shift_clock(sc), .pixel_data_bus(db), .line_latch_pulse(ll),
    .scan_direction_select(dir), .frame_polarity(fr), .forced_blank_n(bl),
    .chain_enable_pin1_in(p1), .chain_enable_pin1_out(o1), .chain_enable_pin1_oe_n(e1),
    .chain_enable_pin2_in(p2), .chain_enable_pin2_out(o2), .chain_enable_pin2_oe_n(e2),
    .column_outputs(col), .fetch_done(dn), .words_taken(wt)
  );
  // ========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2*COLS-1:0] enc(input logic [COLS-1:0] b);
    logic [2*COLS-1:0] e;
    for (int i = 0; i < COLS; i++)
      e[2*i+:2] = bl ? {fr, b[i] ~^ fr} : 2'b00;
    return e;
  endfunction
  task automatic cmp_cnt(input logic [6:0] a, input logic [6:0] e);
    comparisons++;
    if (a !== e)
    begin
      failures++;
      $display("[ERR] %0t chain/count %h exp %h", $time, a, e);
    end
  endtask
  task automatic cmp_col(input logic [2*COLS-1:0] e);
    comparisons++;
    if (col !== e)
    begin
      failures++;
      $display("[ERR] %0t columns differ", $time);
    end
  endtask
  task automatic line(input int n);
    logic [COLS-1:0] b;
    int m;
    b = '0;
    m = hi ? 0 : (n < WORDS ? n : WORDS);
    for (int k = 0; k < n; k++)
    begin
      seed = lfsr(seed);
      for (int j = 0; j < DATA_W; j++)
        if (k < m)
          b[dir ? k*DATA_W+j : COLS-1-k*DATA_W-j] = seed[j];
      ctl.word(seed[DATA_W-1:0]);
    end
    repeat (8) @(negedge clock);
    cmp_cnt({dir ? p2 : p1, dn, wt}, {m != WORDS, m == WORDS, CNT_W'(m)});
    lastb = b;
    q.push_back(enc(b));
    ctl.latch();
  endtask
  task automatic results;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ========
  // result monitor
  initial forever
  begin
    @(negedge ll or poke);
    repeat (12) @(negedge clock);
    if (q.size() > 0)
      cmp_col(q.pop_front());
  end
  // ========
  // main sequence
  initial
  begin
    repeat (3) ctl.word('1);
    @(negedge clock);
    reset = 0;
    // idle shift edges, chain inactive, so the link domain leaves reset
    repeat (3) ctl.word('1);
    repeat (8) @(negedge clock);
    hi = 0;
    line(20);
    for (int v = 0; v < 4; v++)
    begin
      repeat (20) @(negedge clock);
      {bl, fr} = 2'(v);
      q.push_back(enc(lastb));
      -> poke;
    end
    line(22);
    @(negedge clock);
    hi = 1;
    dir = 1;
    repeat (10) @(negedge clock);
    // idle shift edges, chain inactive, so the link domain sees the new direction
    repeat (3) ctl.word('1);
    @(negedge clock);
    hi = 0;
    line(10);
    @(negedge clock);
    hi = 1;
    line(5);
    repeat (20) @(negedge clock);
    results();
  end
  initial
  begin
    #60us;
    failures++;
    results();
  end
endmodule // tb_top
